/* File: core/delay_tap_decoder.sv */
// Turns a four-bit delay code into a one-hot tap select and its delay.
// Assumes the analog delay line has one tap per 250 ps step.
`timescale 1ns/100ps
module delay_tap_decoder
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [3:0] code,
	output logic [15:0] tap_sel,
	output logic [11:0] delay_ps
);

	logic [15:0] tap_ff;
	logic [11:0] delay_ff;
	logic [15:0] nxt_tap;
	logic [11:0] nxt_delay;

	// One tap per code value
	genvar t;
	generate
		for (t = 0; t < lq_pkg::TAP_COUNT; t++)
		begin : g_tap
			assign nxt_tap[t] = (code == 4'(t));
		end
	endgenerate

	// Delay is code plus one steps
	assign nxt_delay = 12'(({8'h00, code} + lq_pkg::DELAY_ONE)
		* lq_pkg::DELAY_STEP_PS);

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			tap_ff <= 16'h0000;
			delay_ff <= 12'h000;
		end
		else
		begin
			tap_ff <= nxt_tap;
			delay_ff <= nxt_delay;
		end
	end

	assign tap_sel = tap_ff;
	assign delay_ps = delay_ff;

endmodule : delay_tap_decoder

/* File: core/link_quality_and_tuning_regs.sv */
// Register bank: link quality report, line driver tuning, clock delays.
// Assumes a one-cycle register port on clk_sys and same-clock inputs
// from the receiver for link state and the measured quality index.
`timescale 1ns/100ps
module link_quality_and_tuning_regs
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	output logic reg_miss,
	input wire logic link_up,
	input wire logic [7:0] quality_index_in,
	output logic [1:0] link_quality,
	output logic [7:0] quality_index_value,
	output logic [4:0] termination_sel,
	output logic [3:0] swing_sel,
	output logic signed [6:0] swing_gain_pct,
	output logic [15:0] tx_delay_tap,
	output logic [11:0] tx_delay_ps,
	output logic [15:0] rx_delay_tap,
	output logic [11:0] rx_delay_ps
);

	// Address match, used by every register
	function automatic logic hit
	(
		input logic [15:0] addr,
		input logic [15:0] offset
	);
		hit = (addr == offset);
	endfunction : hit

	// Stored fields
	logic [4:0] term_ff;
	logic [3:0] swing_ff;
	logic [3:0] txd_ff;
	logic [3:0] rxd_ff;
	logic [15:0] rdata_ff;
	logic miss_ff;
	logic signed [6:0] gain_ff;

	// Next values
	logic [4:0] nxt_term;
	logic [3:0] nxt_swing;
	logic [3:0] nxt_txd;
	logic [3:0] nxt_rxd;
	logic [15:0] nxt_rdata;
	logic nxt_miss;
	logic signed [6:0] nxt_gain;

	// Decode
	wire sel_quality;
	wire sel_term;
	wire sel_swing;
	wire sel_delay;
	wire sel_any;
	wire wr_term;
	wire wr_swing;
	wire wr_delay;

	// Classifier outputs
	lq_pkg::link_quality_t cls_status;
	logic [7:0] cls_index;

	// Read images of each register
	wire [15:0] img_quality;
	wire [15:0] img_term;
	wire [15:0] img_swing;
	wire [15:0] img_delay;
	wire [15:0] read_mux;

	// Swing arithmetic
	wire signed [6:0] swing_steps;
	wire signed [6:0] gain_rst;

	// Field slices of the write data
	wire [4:0] wdata_term;
	wire [3:0] wdata_swing;
	wire [3:0] wdata_txd;
	wire [3:0] wdata_rxd;

	assign sel_quality = hit(reg_addr, lq_pkg::OFF_QUALITY);
	assign sel_term = hit(reg_addr, lq_pkg::OFF_TERM);
	assign sel_swing = hit(reg_addr, lq_pkg::OFF_SWING);
	assign sel_delay = hit(reg_addr, lq_pkg::OFF_DELAY);
	assign sel_any = sel_quality | sel_term | sel_swing | sel_delay;

	// The quality report takes no write
	assign wr_term = reg_wr & sel_term;
	assign wr_swing = reg_wr & sel_swing;
	assign wr_delay = reg_wr & sel_delay;

	// Only the documented fields are taken from a write
	assign wdata_term = reg_wdata[lq_pkg::TERM_MSB:lq_pkg::TERM_LSB];
	assign wdata_swing = reg_wdata[lq_pkg::SWING_MSB:lq_pkg::SWING_LSB];
	assign wdata_txd = reg_wdata[lq_pkg::TXD_MSB:lq_pkg::TXD_LSB];
	assign wdata_rxd = reg_wdata[lq_pkg::RXD_MSB:lq_pkg::RXD_LSB];

	assign nxt_term = wr_term
		? wdata_term
		: term_ff;
	assign nxt_swing = wr_swing
		? wdata_swing
		: swing_ff;
	assign nxt_txd = wr_delay
		? wdata_txd
		: txd_ff;
	assign nxt_rxd = wr_delay
		? wdata_rxd
		: rxd_ff;

	// Gain change in percent relative to the unity code
	assign swing_steps = $signed({3'h0, nxt_swing}) - lq_pkg::SWING_UNITY;
	assign nxt_gain = 7'(swing_steps * lq_pkg::GAIN_STEP_PCT);

	// Reset gain follows from the reset swing code
	assign gain_rst = 7'(($signed({3'h0, lq_pkg::SWING_RST})
		- lq_pkg::SWING_UNITY) * lq_pkg::GAIN_STEP_PCT);

	// Status and index from one snapshot
	quality_classifier u_classifier
	(
		.clk_sys(clk_sys),
		.reset(reset),
		.link_up(link_up),
		.index_in(quality_index_in),
		.status(cls_status),
		.index_out(cls_index)
	);

	// Transmit clock path delay taps
	delay_tap_decoder u_tx_delay
	(
		.clk_sys(clk_sys),
		.reset(reset),
		.code(txd_ff),
		.tap_sel(tx_delay_tap),
		.delay_ps(tx_delay_ps)
	);

	// Receive clock path delay taps
	delay_tap_decoder u_rx_delay
	(
		.clk_sys(clk_sys),
		.reset(reset),
		.code(rxd_ff),
		.tap_sel(rx_delay_tap),
		.delay_ps(rx_delay_ps)
	);

	// Read images with reserved bits at zero
	assign img_quality = {6'h00, cls_status, cls_index};
	assign img_term = {3'h0, term_ff, 8'h00};
	assign img_swing = {12'h000, swing_ff};
	assign img_delay = {8'h00, txd_ff, rxd_ff};

	assign read_mux = sel_quality ? img_quality
		: sel_term ? img_term
		: sel_swing ? img_swing
		: sel_delay ? img_delay
		: 16'h0000;

	// Read data stand for one cycle only
	assign nxt_rdata = reg_rd ? read_mux : 16'h0000;

	// Flag an access to an address with no register
	assign nxt_miss = (reg_rd | reg_wr) & ~sel_any;

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			term_ff <= lq_pkg::TERM_RST;
		end
		else
		begin
			term_ff <= nxt_term;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			swing_ff <= lq_pkg::SWING_RST;
		end
		else
		begin
			swing_ff <= nxt_swing;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			txd_ff <= lq_pkg::TXD_RST;
		end
		else
		begin
			txd_ff <= nxt_txd;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			rxd_ff <= lq_pkg::RXD_RST;
		end
		else
		begin
			rxd_ff <= nxt_rxd;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			gain_ff <= gain_rst;
		end
		else
		begin
			gain_ff <= nxt_gain;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			rdata_ff <= 16'h0000;
		end
		else
		begin
			rdata_ff <= nxt_rdata;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			miss_ff <= 1'b0;
		end
		else
		begin
			miss_ff <= nxt_miss;
		end
	end

	assign reg_rdata = rdata_ff;
	assign reg_miss = miss_ff;
	assign link_quality = cls_status;
	assign quality_index_value = cls_index;
	assign termination_sel = term_ff;
	assign swing_sel = swing_ff;
	assign swing_gain_pct = gain_ff;

endmodule : link_quality_and_tuning_regs

/* File: core/lq_pkg.sv */
// Constants for the link quality and transmitter tuning register bank.
// Assumes a 16-bit register port on the single system clock.
package lq_pkg;

	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;

	// Register offsets
	localparam logic [15:0] OFF_QUALITY = 16'h0198;
	localparam logic [15:0] OFF_TERM = 16'h0400;
	localparam logic [15:0] OFF_SWING = 16'h0401;
	localparam logic [15:0] OFF_DELAY = 16'h0446;

	// Field positions
	localparam int STAT_MSB = 9;
	localparam int STAT_LSB = 8;
	localparam int INDEX_MSB = 7;
	localparam int INDEX_LSB = 0;
	localparam int TERM_MSB = 12;
	localparam int TERM_LSB = 8;
	localparam int SWING_MSB = 3;
	localparam int SWING_LSB = 0;
	localparam int TXD_MSB = 7;
	localparam int TXD_LSB = 4;
	localparam int RXD_MSB = 3;
	localparam int RXD_LSB = 0;

	// Reset values
	localparam logic [4:0] TERM_RST = 5'h10;
	localparam logic [3:0] SWING_RST = 4'ha;
	localparam logic [3:0] TXD_RST = 4'h7;
	localparam logic [3:0] RXD_RST = 4'h7;

	// Quality thresholds on the index
	localparam logic [7:0] EXCELLENT_ABOVE = 8'h46;
	localparam logic [7:0] GOOD_FROM = 8'h28;

	// Swing trim: unity code and percent per code step
	localparam logic signed [6:0] SWING_UNITY = 7'sh08;
	localparam logic signed [6:0] GAIN_STEP_PCT = 7'sh02;

	// Clock path delay: step in picoseconds, tap count
	localparam logic [11:0] DELAY_STEP_PS = 12'h0fa;
	localparam logic [11:0] DELAY_ONE = 12'h001;
	localparam int TAP_COUNT = 16;

	typedef enum logic [1:0]
	{
		LQ_NO_LINK = 2'h0,
		LQ_POOR = 2'h1,
		LQ_GOOD = 2'h2,
		LQ_EXCELLENT = 2'h3
	} link_quality_t;

endpackage : lq_pkg

/* File: core/quality_classifier.sv */
// Classifies the measured quality index into a link quality status.
// Assumes link state and index come from logic on the same clock.
`timescale 1ns/100ps
module quality_classifier
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic link_up,
	input wire logic [7:0] index_in,
	output lq_pkg::link_quality_t status,
	output logic [7:0] index_out
);

	function automatic lq_pkg::link_quality_t classify
	(
		input logic up,
		input logic [7:0] idx
	);
		if (!up)
			classify = lq_pkg::LQ_NO_LINK;
		else if (idx > lq_pkg::EXCELLENT_ABOVE)
			classify = lq_pkg::LQ_EXCELLENT;
		else if (idx >= lq_pkg::GOOD_FROM)
			classify = lq_pkg::LQ_GOOD;
		else
			classify = lq_pkg::LQ_POOR;
	endfunction : classify

	lq_pkg::link_quality_t status_ff;
	logic [7:0] index_ff;
	lq_pkg::link_quality_t nxt_status;

	// Status and index captured together so they never disagree
	assign nxt_status = classify(link_up, index_in);

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			status_ff <= lq_pkg::LQ_NO_LINK;
			index_ff <= 8'h00;
		end
		else
		begin
			status_ff <= nxt_status;
			index_ff <= index_in;
		end
	end

	assign status = status_ff;
	assign index_out = index_ff;

endmodule : quality_classifier

/* File: dv/lq_sva.sv */
// Checker for the link quality and tuning register bank.
// Bound to the top module; sees only its ports.
`timescale 1ns/100ps
module lq_sva
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic link_up,
	input wire logic [7:0] quality_index_in,
	input wire logic [1:0] link_quality,
	input wire logic [7:0] quality_index_value,
	input wire logic [3:0] swing_sel,
	input wire logic signed [6:0] swing_gain_pct,
	input wire logic [15:0] tx_delay_tap,
	input wire logic [11:0] tx_delay_ps,
	input wire logic [11:0] rx_delay_ps
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	no_link_a: assert property (!link_up
		|=> link_quality == 2'h0) else $error("status set without link");
	excellent_link_a: assert property (link_up
		&& quality_index_in > 8'h46 |=> link_quality == 2'h3)
		else $error("not excellent");
	good_link_a: assert property (link_up
		&& quality_index_in >= 8'h28 && quality_index_in <= 8'h46
		|=> link_quality == 2'h2) else $error("not good");
	poor_link_a: assert property (link_up
		&& quality_index_in < 8'h28 |=> link_quality == 2'h1)
		else $error("not poor");
	status_index_a: assert property (link_quality == 2'h3
		|-> quality_index_value > 8'h46) else $error("index disagrees");
	quality_read_a: assert property (reg_rd
		&& reg_addr == 16'h0198 |=> reg_rdata == {6'h00,
		$past(link_quality), $past(quality_index_value)})
		else $error("bad quality read");
	gain_map_a: assert property (!$past(reset)
		|-> swing_gain_pct == 7'((swing_sel - 4'h8) * 7'h02))
		else $error("bad gain");
	tx_map_a: assert property ($onehot(tx_delay_tap)
		|-> tx_delay_ps == 12'(($clog2(tx_delay_tap) + 1) * 12'h0fa))
		else $error("bad ps");
	delay_write_a: assert property (reg_wr
		&& reg_addr == 16'h0446 ##1 !(reg_wr && reg_addr == 16'h0446)
		|=> tx_delay_tap == 16'(16'h0001 << $past(reg_wdata[7:4], 2))
		&& rx_delay_ps == 12'(($past(reg_wdata[3:0], 2) + 12'h001)
		* 12'h0fa)) else $error("delay write lost");
endmodule : lq_sva

bind link_quality_and_tuning_regs lq_sva lq_chk (.clk_sys(clk_sys),
	.reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.link_up(link_up), .quality_index_in(quality_index_in),
	.link_quality(link_quality), .quality_index_value(quality_index_value),
	.swing_sel(swing_sel), .swing_gain_pct(swing_gain_pct),
	.tx_delay_tap(tx_delay_tap), .tx_delay_ps(tx_delay_ps),
	.rx_delay_ps(rx_delay_ps));

/* File: dv/testbench.sv */
// Self-checking bench for the link quality and tuning register bank.
// Drives the register port and receiver inputs directly.
`timescale 1ns/100ps
module testbench;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic [15:0] reg_addr = 16'h0000;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic link_up = 1'b0;
	logic [7:0] quality_index_in = 8'h00;
	logic [15:0] reg_rdata;
	logic [1:0] link_quality;
	logic [7:0] quality_index_value;
	logic [4:0] termination_sel;
	logic [3:0] swing_sel;
	logic signed [6:0] swing_gain_pct;
	logic [15:0] tx_delay_tap;
	logic [15:0] rx_delay_tap;
	logic [11:0] tx_delay_ps;
	logic [11:0] rx_delay_ps;
	logic reg_miss;
	int mismatches = 0;
	int samples_checked = 0;
	// Rows: link up, index, expected status
	logic [10:0] rows [7] = '{{1'b0, 8'h50, 2'h0}, {1'b1, 8'h00, 2'h1},
		{1'b1, 8'h27, 2'h1}, {1'b1, 8'h28, 2'h2}, {1'b1, 8'h46, 2'h2},
		{1'b1, 8'h47, 2'h3}, {1'b1, 8'hff, 2'h3}};
	always #5 clk_sys = ~clk_sys;
	link_quality_and_tuning_regs uut (.clk_sys(clk_sys), .reset(reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_miss(reg_miss),
		.link_up(link_up), .quality_index_in(quality_index_in),
		.link_quality(link_quality), .quality_index_value(quality_index_value),
		.termination_sel(termination_sel), .swing_sel(swing_sel),
		.swing_gain_pct(swing_gain_pct),
		.tx_delay_tap(tx_delay_tap), .tx_delay_ps(tx_delay_ps),
		.rx_delay_tap(rx_delay_tap), .rx_delay_ps(rx_delay_ps));
	task automatic chk(input string n, logic [15:0] e, logic [15:0] g);
		samples_checked++;
		if (g !== e)
		begin
			mismatches++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic op(input logic w, logic r, logic [15:0] a, logic [15:0] d);
		@(posedge clk_sys);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= d;
	endtask : op
	task automatic rd(input logic [15:0] a, logic [15:0] e);
		op(1'b0, 1'b1, a, 16'h0000);
		op(1'b0, 1'b0, a, 16'h0000);
		#1 chk("reg_rdata", e, reg_rdata);
	endtask : rd
	task automatic conclude;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude
	initial
	begin
		repeat (1000) @(posedge clk_sys);
		mismatches++;
		conclude();
	end
	initial
	begin
		repeat (8) @(posedge clk_sys);
		reset <= 1'b0;
		foreach (rows[i])
		begin
			@(posedge clk_sys);
			link_up <= rows[i][10];
			quality_index_in <= rows[i][9:2];
			rd(16'h0198, {6'h00, rows[i][1:0],
				rows[i][9:2]});
			chk("link_quality", {14'h0000, rows[i][1:0]},
				{14'h0000, link_quality});
			chk("quality_index_value", {8'h00, rows[i][9:2]},
				{8'h00, quality_index_value});
		end
		$display("test quality done");
		rd(16'h0400, 16'h1000);
		chk("termination_sel", 16'h0010,
			{11'h000, termination_sel});
		rd(16'h0401, 16'h000a);
		chk("swing_sel", 16'h000a, {12'h000, swing_sel});
		rd(16'h0446, 16'h0077);
		chk("rx_delay_ps", 16'h07d0, {4'h0, rx_delay_ps});
		op(1'b1, 1'b0, 16'h0400, 16'hffff);
		rd(16'h0400, 16'h1f00);
		chk("termination_sel", 16'h001f,
			{11'h000, termination_sel});
		op(1'b1, 1'b0, 16'h0401, 16'hffff);
		rd(16'h0401, 16'h000f);
		chk("swing_gain_pct", 16'h000e, {9'h000, swing_gain_pct});
		op(1'b1, 1'b0, 16'h0401, 16'h0000);
		rd(16'h0401, 16'h0000);
		chk("swing_gain_pct", 16'h0070, {9'h000, swing_gain_pct});
		op(1'b1, 1'b0, 16'h0446, 16'hffa3);
		rd(16'h0446, 16'h00a3);
		chk("tx_delay_tap", 16'h0400, tx_delay_tap);
		chk("tx_delay_ps", 16'h0abe, {4'h0, tx_delay_ps});
		chk("rx_delay_tap", 16'h0008, rx_delay_tap);
		chk("rx_delay_ps", 16'h03e8, {4'h0, rx_delay_ps});
		$display("test writes done");
		op(1'b1, 1'b0, 16'h0198, 16'h0000);
		rd(16'h0198, 16'h03ff);
		rd(16'h0123, 16'h0000);
		chk("reg_miss", 16'h0001, {15'h0000, reg_miss});
		op(1'b1, 1'b0, 16'h0123, 16'hffff);
		op(1'b0, 1'b0, 16'h0123, 16'h0000);
		#1 chk("reg_miss", 16'h0001, {15'h0000, reg_miss});
		@(posedge clk_sys);
		reset <= 1'b1;
		@(posedge clk_sys);
		reset <= 1'b0;
		rd(16'h0401, 16'h000a);
		chk("swing_gain_pct", 16'h0004, {9'h000, swing_gain_pct});
		rd(16'h0446, 16'h0077);
		$display("test reset done");
		conclude();
	end
endmodule : testbench
